// [hw/exint_select.v]
`timescale 1ns/100ps
`default_nettype none
`include "exint_defines.vh"
// Function
// - edge code 00 is standard mode; input ignored for power-down.
// - code 01 requests on rising edge of selected input.
// - code 01 enters power-down only when input low, wakes on high.
// - code 10 requests on falling edge of selected input.
// - code 10 enters power-down only when input high, wakes on low.
// - code 11 requests on both edges.
// - code 11 always allows power-down, wakes on any level change.
// - edge register: eight 2-bit fields, channel x at 2x+1:2x, reset 0.
// - source field: 00 pin, 01 alternate, 10 OR, 11 AND.
// - control byte: flag 7, enable 6, priority 5:2, group 1:0, reset 0.
// - flag shows pending request; enable gates it into arbitration.
// - arbitration favours higher priority level, Fh highest.
// - equal priority ordered by group level, 3 highest.
module exint_select (
    input  wire        CORE_CLK_I,
    input  wire        RESET_N_I,
    input  wire        PSEL_I,
    input  wire        PENABLE_I,
    input  wire        PWRITE_I,
    input  wire [15:0] PADDR_I,
    input  wire [31:0] PWDATA_I,
    output reg  [31:0] PRDATA_O,
    output wire        PREADY_O,
    output wire        PSLVERR_O,
    input  wire [7:0]  PORT2_HIGH_I,
    input  wire        FIRST_CAN_RECEIVE_LINE_I,
    input  wire        SECOND_CAN_RECEIVE_LINE_I,
    input  wire        RTC_SECONDS_TICK_I,
    input  wire        RTC_ALARM_TICK_I,
    input  wire        PD_ENTRY_I,
    output reg  [7:0]  CHANNEL_REQUEST_O,
    output reg         PD_ALLOW_O,
    output reg         PD_WAKE_O,
    output reg         XPER3_ARB_REQUEST_O,
    output reg  [5:0]  XPER3_ARB_RANK_O,
    input  wire        XPER3_EVENT_I,
    input  wire        XPER3_ACK_I,
    output wire        IRQ_O
);
    localparam CHANNELS = 8;
    // ==========================================================
    // pin synchronisers
    reg  [7:0]  pin_s1_reg;
    reg  [7:0]  pin_s2_reg;
    reg  [3:0]  alt_s1_reg;
    reg  [3:0]  alt_s2_reg;
    wire [7:0]  alt_in;
    wire [7:0]  edge_pulse;
    wire [7:0]  pd_allow;
    wire [7:0]  pd_wake;
    reg  [15:0] ext_irq_edge_config_reg;
    reg  [15:0] ext_irq_source_config_reg;
    reg  [7:0]  xper3_irq_control_reg;
    reg  [7:0]  irq_status_reg;
    reg  [7:0]  irq_mask_reg;
    reg  [31:0] rdata_next;
    reg         addr_hit;
    wire        wr_en;
    wire        rd_en;

    always @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            pin_s1_reg <= 8'h00;
            pin_s2_reg <= 8'h00;
            alt_s1_reg <= 4'h0;
            alt_s2_reg <= 4'h0;
        end else begin
            pin_s1_reg <= PORT2_HIGH_I;
            pin_s2_reg <= pin_s1_reg;
            alt_s1_reg <= {RTC_ALARM_TICK_I, RTC_SECONDS_TICK_I,
                           SECOND_CAN_RECEIVE_LINE_I,
                           FIRST_CAN_RECEIVE_LINE_I};
            alt_s2_reg <= alt_s1_reg;
        end
    end

    // unused alternates tied low
    assign alt_in = {4'h0, alt_s2_reg};

    // ==========================================================
    // channels
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : ch
            exint_channel u_ch (
                .clk_i        (CORE_CLK_I),
                .reset_n_i    (RESET_N_I),
                .pin_i        (pin_s2_reg[g]),
                .alt_i        (alt_in[g]),
                .edge_sel_i   (ext_irq_edge_config_reg[2*g+1:2*g]),
                .src_sel_i    (ext_irq_source_config_reg[2*g+1:2*g]),
                .pd_entry_i   (PD_ENTRY_I),
                .edge_pulse_o (edge_pulse[g]),
                .pd_allow_o   (pd_allow[g]),
                .pd_wake_o    (pd_wake[g])
            );
        end
    endgenerate

    // ==========================================================
    // apb decode
    assign PREADY_O  = 1'b1;
    assign wr_en = PSEL_I & PENABLE_I & PWRITE_I;
    assign rd_en = PSEL_I & ~PWRITE_I;
    // unmapped addresses answer with an error rather than silence
    assign PSLVERR_O = PSEL_I & PENABLE_I & ~addr_hit;

    always @* begin
        rdata_next = 32'h00000000;
        addr_hit   = 1'b1;
        if (PADDR_I == `EXT_IRQ_EDGE_CONFIG_ADDR) begin
            rdata_next = {16'h0000, ext_irq_edge_config_reg};
        end else if (PADDR_I == `EXT_IRQ_SOURCE_CONFIG_ADDR) begin
            rdata_next = {16'h0000, ext_irq_source_config_reg};
        end else if (PADDR_I == `XPER3_IRQ_CONTROL_ADDR) begin
            rdata_next = {24'h000000, xper3_irq_control_reg};
        end else if (PADDR_I == `IRQ_STATUS_ADDR) begin
            rdata_next = {24'h000000, irq_status_reg};
        end else if (PADDR_I == `IRQ_MASK_ADDR) begin
            rdata_next = {24'h000000, irq_mask_reg};
        end else if (PADDR_I == `PD_STATUS_ADDR) begin
            rdata_next = {16'h0000, pd_wake, pd_allow};
        end else begin
            addr_hit = 1'b0;
        end
    end

    // read data registered in setup, valid through access
    always @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            PRDATA_O <= 32'h00000000;
        end else if (rd_en & ~PENABLE_I) begin
            PRDATA_O <= rdata_next;
        end
    end

    // ==========================================================
    // registers
    always @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            ext_irq_edge_config_reg   <= `EDGE_CONFIG_RESET;
            ext_irq_source_config_reg <= `SOURCE_CONFIG_RESET;
            irq_mask_reg              <= `IRQ_MASK_RESET;
        end else if (wr_en) begin
            if (PADDR_I == `EXT_IRQ_EDGE_CONFIG_ADDR) begin
                ext_irq_edge_config_reg <= PWDATA_I[15:0];
            end else if (PADDR_I == `EXT_IRQ_SOURCE_CONFIG_ADDR) begin
                ext_irq_source_config_reg <= PWDATA_I[15:0];
            end else if (PADDR_I == `IRQ_MASK_ADDR) begin
                irq_mask_reg <= PWDATA_I[7:0];
            end
        end
    end

    // flag: hardware set beats software write and acknowledge
    always @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            xper3_irq_control_reg <= `XPER3_RESET;
        end else begin
            if (wr_en && PADDR_I == `XPER3_IRQ_CONTROL_ADDR) begin
                xper3_irq_control_reg <= PWDATA_I[7:0];
            end else if (XPER3_ACK_I) begin
                xper3_irq_control_reg[`XPER3_FLAG_BIT] <= 1'b0;
            end
            if (XPER3_EVENT_I) begin
                xper3_irq_control_reg[`XPER3_FLAG_BIT] <= 1'b1;
            end
        end
    end

    // sticky channel status, write one to clear, set wins
    always @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            irq_status_reg <= 8'h00;
        end else if (wr_en && PADDR_I == `IRQ_STATUS_ADDR) begin
            irq_status_reg <= (irq_status_reg & ~PWDATA_I[7:0])
                              | edge_pulse;
        end else begin
            irq_status_reg <= irq_status_reg | edge_pulse;
        end
    end

    assign IRQ_O = |(irq_status_reg & irq_mask_reg);

    // ==========================================================
    // outputs
    always @(posedge CORE_CLK_I) begin
        if (!RESET_N_I) begin
            CHANNEL_REQUEST_O   <= 8'h00;
            PD_ALLOW_O          <= 1'b1;
            PD_WAKE_O           <= 1'b0;
            XPER3_ARB_REQUEST_O <= 1'b0;
            XPER3_ARB_RANK_O    <= 6'h00;
        end else begin
            CHANNEL_REQUEST_O <= edge_pulse;
            PD_ALLOW_O        <= &pd_allow;
            PD_WAKE_O         <= |pd_wake;
            XPER3_ARB_REQUEST_O <=
                xper3_irq_control_reg[`XPER3_FLAG_BIT] &
                xper3_irq_control_reg[`XPER3_ENABLE_BIT];
            // priority in upper bits so it dominates group
            XPER3_ARB_RANK_O <= {
                xper3_irq_control_reg[`PRIO_MSB:`PRIO_LSB],
                xper3_irq_control_reg[`GROUP_MSB:`GROUP_LSB]};
        end
    end
endmodule
`default_nettype wire

// [hw/exint_defines.vh]
`ifndef EXINT_DEFINES_VH
`define EXINT_DEFINES_VH
// ==========================================================
// register byte addresses
`define XPER3_IRQ_CONTROL_ADDR     16'hF19E
`define EXT_IRQ_EDGE_CONFIG_ADDR   16'hF1C0
`define EXT_IRQ_SOURCE_CONFIG_ADDR 16'hF1DA
`define IRQ_STATUS_ADDR            16'hF1E0
`define IRQ_MASK_ADDR              16'hF1E4
`define PD_STATUS_ADDR             16'hF1E8
// ==========================================================
// reset values
`define EDGE_CONFIG_RESET          16'h0000
`define SOURCE_CONFIG_RESET        16'h0000
`define XPER3_RESET                8'h00
`define IRQ_MASK_RESET             8'h00
// ==========================================================
// field positions of the control register
`define XPER3_FLAG_BIT             7
`define XPER3_ENABLE_BIT           6
`define PRIO_MSB                   5
`define PRIO_LSB                   2
`define GROUP_MSB                  1
`define GROUP_LSB                  0
// ==========================================================
// edge field codes
`define EDGE_STANDARD              2'h0
`define EDGE_RISING                2'h1
`define EDGE_FALLING               2'h2
`define EDGE_ANY                   2'h3
// source field codes
`define SRC_PIN                    2'h0
`define SRC_ALT                    2'h1
`define SRC_OR                     2'h2
`define SRC_AND                    2'h3
`endif

// [hw/exint_channel.v]
`timescale 1ns/100ps
`default_nettype none
`include "exint_defines.vh"
// ==========================================================
// one channel: source mux, edge detect, power-down terms
module exint_channel (
    input  wire       clk_i,
    input  wire       reset_n_i,
    input  wire       pin_i,
    input  wire       alt_i,
    input  wire [1:0] edge_sel_i,
    input  wire [1:0] src_sel_i,
    input  wire       pd_entry_i,
    output wire       edge_pulse_o,
    output wire       pd_allow_o,
    output wire       pd_wake_o
);
    reg  sel_in;
    reg  prev_reg;
    reg  entry_level_reg;
    wire rise;
    wire fall;

    always @* begin
        case (src_sel_i)
            `SRC_PIN: sel_in = pin_i;
            `SRC_ALT: sel_in = alt_i;
            `SRC_OR:  sel_in = pin_i | alt_i;
            default:  sel_in = pin_i & alt_i;
        endcase
    end

    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            prev_reg        <= 1'b0;
            entry_level_reg <= 1'b0;
        end else begin
            prev_reg <= sel_in;
            // level remembered while not in power-down
            if (!pd_entry_i) begin
                entry_level_reg <= sel_in;
            end
        end
    end

    assign rise = sel_in & ~prev_reg;
    assign fall = ~sel_in & prev_reg;

    assign edge_pulse_o =
        (edge_sel_i == `EDGE_RISING)  ? rise :
        (edge_sel_i == `EDGE_FALLING) ? fall :
        (edge_sel_i == `EDGE_ANY)     ? (rise | fall) :
        1'b0;

    assign pd_allow_o =
        (edge_sel_i == `EDGE_RISING)  ? ~sel_in :
        (edge_sel_i == `EDGE_FALLING) ? sel_in :
        1'b1;

    assign pd_wake_o = pd_entry_i & (
        (edge_sel_i == `EDGE_RISING)  ? sel_in :
        (edge_sel_i == `EDGE_FALLING) ? ~sel_in :
        (edge_sel_i == `EDGE_ANY)     ? (sel_in ^ entry_level_reg) :
        1'b0);
endmodule
`default_nettype wire

// [testbench/exint_assertions.sv]
`timescale 1ns/100ps
`default_nettype none
`include "exint_defines.vh"
// ==========================================
// port-level checks
module exint_assertions (
    input wire logic        CORE_CLK_I,
    input wire logic        RESET_N_I,
    input wire logic        PSEL_I,
    input wire logic        PENABLE_I,
    input wire logic        PWRITE_I,
    input wire logic [15:0] PADDR_I,
    input wire logic        PREADY_O,
    input wire logic        PSLVERR_O,
    input wire logic        PD_ENTRY_I,
    input wire logic [7:0]  CHANNEL_REQUEST_O,
    input wire logic        PD_ALLOW_O,
    input wire logic        PD_WAKE_O,
    input wire logic        XPER3_ARB_REQUEST_O,
    input wire logic [5:0]  XPER3_ARB_RANK_O,
    input wire logic        XPER3_EVENT_I,
    input wire logic        XPER3_ACK_I,
    input wire logic        IRQ_O
);
    wire acc  = PSEL_I && PENABLE_I;
    wire wr   = acc && PWRITE_I;
    wire wctl = wr && PADDR_I == `XPER3_IRQ_CONTROL_ADDR;
    // status and mask share one aligned pair of words
    wire irqa = PADDR_I[15:3] == 13'h1E3C && PADDR_I[1:0] == 2'h0;
    wire wirq = wr && irqa;
    wire map  = irqa || PADDR_I == `XPER3_IRQ_CONTROL_ADDR
        || PADDR_I == `EXT_IRQ_EDGE_CONFIG_ADDR
        || PADDR_I == `EXT_IRQ_SOURCE_CONFIG_ADDR
        || PADDR_I == `PD_STATUS_ADDR;
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESET_N_I);
    AST_RESET_STATE: assert property (
        $rose(RESET_N_I) |-> CHANNEL_REQUEST_O == 8'h00 && PD_ALLOW_O
        && !PD_WAKE_O && !IRQ_O && XPER3_ARB_RANK_O == 6'h00)
        else $error("outputs not at reset state");
    AST_APB_RESP: assert property (
        acc |-> PREADY_O && PSLVERR_O == !map)
        else $error("bad apb response");
    AST_WAKE_GATE: assert property (
        !PD_ENTRY_I && !$past(PD_ENTRY_I) |-> !PD_WAKE_O)
        else $error("wake outside power-down");
    AST_ARB_ACK: assert property (
        XPER3_ACK_I && !XPER3_EVENT_I && !wctl ##1 !XPER3_EVENT_I
        |=> !XPER3_ARB_REQUEST_O)
        else $error("request kept after ack");
    AST_ARB_RISE: assert property (
        $rose(XPER3_ARB_REQUEST_O) |-> $past(XPER3_EVENT_I)
        || $past(XPER3_EVENT_I, 2) || $past(wctl) || $past(wctl, 2))
        else $error("request without cause");
    AST_RANK_CHG: assert property (
        $changed(XPER3_ARB_RANK_O) |-> $past(wctl) || $past(wctl, 2))
        else $error("rank changed without write");
    AST_IRQ_RISE: assert property (
        $rose(IRQ_O) |-> CHANNEL_REQUEST_O != 8'h00 || $past(wirq))
        else $error("irq raised without event");
    AST_IRQ_FALL: assert property (
        $fell(IRQ_O) |-> $past(wirq))
        else $error("irq dropped without write");
    COV_IRQ: cover property ($rose(IRQ_O));
    COV_WAKE: cover property ($rose(PD_WAKE_O));
    COV_ERR: cover property (acc && PSLVERR_O);
endmodule
`default_nettype wire

// [testbench/exint_pins_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port pins and alternate sources
module exint_pins_model (
    input  wire logic       clk_i,
    input  wire logic [7:0] pin_cmd_i,
    input  wire logic [3:0] alt_cmd_i,
    output var  logic [7:0] pins_o,
    output var  logic [3:0] alt_o
);
    // only four alternate lines: channels 4-7 have none
    initial begin
        pins_o = 8'h00;
        alt_o  = 4'h0;
    end
    always @(posedge clk_i) begin
        pins_o <= pin_cmd_i;
        alt_o  <= alt_cmd_i;
    end
endmodule
`default_nettype wire

// [testbench/external_interrupt_select_test.sv]
`timescale 1ns/100ps
`default_nettype none
`include "exint_defines.vh"
// ==========================================
// bench
module external_interrupt_select_test;
    logic        clk, rst_n, psel, pen, pwr, pd, xev, xack;
    logic [15:0] paddr, edg, src;
    logic [31:0] pwdata, seed, r;
    logic [7:0]  pcmd, pins;
    logic [3:0]  acmd, alts;
    wire  [31:0] prdata;
    wire  [7:0]  req;
    wire  [5:0]  rank;
    wire         pready, pslverr, allow, wake, arb, irq;
    int          errors, total_checks, m;
    logic [31:0] rd_q[$];
    logic [7:0]  ch_q[$];
    exint_select exint_select_inst (.CORE_CLK_I(clk), .RESET_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
        .PSLVERR_O(pslverr), .PORT2_HIGH_I(pins), .PD_ENTRY_I(pd),
        .FIRST_CAN_RECEIVE_LINE_I(alts[0]), .RTC_ALARM_TICK_I(alts[3]),
        .SECOND_CAN_RECEIVE_LINE_I(alts[1]), .RTC_SECONDS_TICK_I(alts[2]),
        .CHANNEL_REQUEST_O(req), .PD_ALLOW_O(allow), .PD_WAKE_O(wake),
        .XPER3_ARB_REQUEST_O(arb), .XPER3_ARB_RANK_O(rank),
        .XPER3_EVENT_I(xev), .XPER3_ACK_I(xack), .IRQ_O(irq));
    exint_pins_model exint_pins_model_inst (.clk_i(clk), .pin_cmd_i(pcmd),
        .alt_cmd_i(acmd), .pins_o(pins), .alt_o(alts));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task close_out;
        $display("checks=%0d errors=%0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int n;
        if (!w) rd_q.push_back(d);
        psel <= 1'b1; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge clk); pen <= 1'b1; n = 0;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin errors++; close_out; end
        psel <= 1'b0; pen <= 1'b0; @(posedge clk);
    endtask
    function logic sel(input logic [1:0] s, input logic p, input logic a);
        return s == 2'h0 ? p : s == 2'h1 ? a : s == 2'h2 ? p | a : p & a;
    endfunction
    task cfg(input logic [15:0] e, input logic [15:0] s);
        edg = e; src = s;
        apb(1'b1, `EXT_IRQ_EDGE_CONFIG_ADDR, {16'h0, e});
        apb(1'b1, `EXT_IRQ_SOURCE_CONFIG_ADDR, {16'h0, s});
        repeat (3) @(posedge clk);
    endtask
    // expected pulses worked out before the pins move
    task step(input logic [7:0] p, input logic [3:0] a);
        logic [7:0] v; logic o, n; logic [1:0] e; int i;
        for (i = 0; i < 8; i++) begin
            o = sel(src[2*i+:2], pcmd[i], i < 4 && acmd[i[1:0]]);
            n = sel(src[2*i+:2], p[i], i < 4 && a[i[1:0]]);
            e = edg[2*i+:2];
            v[i] = (e == 2'h1 && n && !o) || (e == 2'h2 && o && !n)
                || (e == 2'h3 && o != n);
        end
        if (v != 8'h00) ch_q.push_back(v);
        pcmd <= p; acmd <= a;
        repeat (8) @(posedge clk);
    endtask
    task evt(input logic ack);
        if (ack) xack <= 1'b1; else xev <= 1'b1;
        @(posedge clk); xack <= 1'b0; xev <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    // outputs stay unknown until the first reset edge
    always @(posedge clk) begin
        if (psel && pen && !pwr && pready === 1'b1)
            chk(prdata, rd_q.pop_front());
        if (rst_n && req !== 8'h00) chk(32'(req), ch_q.size()
            ? 32'(ch_q.pop_front()) : 32'h0);
    end
    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 16'h0;
        pwdata = 32'h0; pd = 1'b0; xev = 1'b0; xack = 1'b0; pcmd = 8'h00;
        acmd = 4'h0; edg = 16'h0; src = 16'h0; seed = 36;
        errors = 0; total_checks = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1; @(posedge clk);
        apb(1'b0, `EXT_IRQ_EDGE_CONFIG_ADDR, 32'h0);
        apb(1'b0, `EXT_IRQ_SOURCE_CONFIG_ADDR, 32'h0);
        apb(1'b0, `XPER3_IRQ_CONTROL_ADDR, 32'h0);
        apb(1'b0, 16'hF1F0, 32'h0);
        r = $random(seed);
        apb(1'b1, `EXT_IRQ_EDGE_CONFIG_ADDR, r);
        apb(1'b0, `EXT_IRQ_EDGE_CONFIG_ADDR, {16'h0, r[15:0]});
        for (m = 0; m < 4; m++) begin
            cfg({8{m[1:0]}}, 16'h0);
            step(8'hFF, 4'h0); step(8'hA5, 4'h0); step(8'h00, 4'h0);
        end
        for (m = 0; m < 4; m++) begin
            cfg(16'hFFFF, {8{m[1:0]}});
            step(8'hFF, 4'h0); step(8'hFF, 4'hF); step(8'h00, 4'h0);
        end
        for (m = 0; m < 4; m++) begin
            cfg({8{m[1:0]}}, 16'h0);
            chk(32'(allow), 32'(m != 2));
            step(8'hFF, 4'h0); chk(32'(allow), 32'(m != 1));
            pd <= 1'b1; repeat (3) @(posedge clk);
            chk(32'(wake), 32'(m == 1));
            apb(1'b0, `PD_STATUS_ADDR,
                {16'h0, {8{m == 1}}, {8{m != 1}}});
            step(8'h00, 4'h0); chk(32'(wake), 32'(m >= 2));
            pd <= 1'b0; repeat (3) @(posedge clk);
        end
        apb(1'b0, `IRQ_STATUS_ADDR, 32'hFF);
        chk(32'(irq), 32'h0);
        apb(1'b1, `IRQ_MASK_ADDR, 32'h01);
        chk(32'(irq), 32'h1);
        apb(1'b1, `IRQ_STATUS_ADDR, 32'h01);
        chk(32'(irq), 32'h0);
        apb(1'b0, `IRQ_STATUS_ADDR, 32'hFE);
        r = $random(seed);
        apb(1'b1, `XPER3_IRQ_CONTROL_ADDR, {24'h0, 2'h1, r[5:0]});
        apb(1'b0, `XPER3_IRQ_CONTROL_ADDR, {24'h0, 2'h1, r[5:0]});
        chk(32'(rank), 32'(r[5:0]));
        evt(1'b0); chk(32'(arb), 32'h1);
        apb(1'b0, `XPER3_IRQ_CONTROL_ADDR, {24'h0, 2'h3, r[5:0]});
        evt(1'b1); chk(32'(arb), 32'h0);
        apb(1'b1, `XPER3_IRQ_CONTROL_ADDR, {24'h0, 2'h0, r[5:0]});
        evt(1'b0); chk(32'(arb), 32'h0);
        apb(1'b0, `XPER3_IRQ_CONTROL_ADDR, {24'h0, 2'h2, r[5:0]});
        chk(32'(ch_q.size()), 32'h0);
        close_out;
    end
endmodule
bind exint_select exint_assertions exint_assertions_inst (
    .CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .PD_ENTRY_I(PD_ENTRY_I),
    .CHANNEL_REQUEST_O(CHANNEL_REQUEST_O), .PD_ALLOW_O(PD_ALLOW_O),
    .PD_WAKE_O(PD_WAKE_O), .XPER3_ARB_REQUEST_O(XPER3_ARB_REQUEST_O),
    .XPER3_ARB_RANK_O(XPER3_ARB_RANK_O), .XPER3_EVENT_I(XPER3_EVENT_I),
    .XPER3_ACK_I(XPER3_ACK_I), .IRQ_O(IRQ_O));
`default_nettype wire
